// ---- src/pcl_top.sv ----
// Clock ratio selection, domain gating and low power sequencing.
// Assumes a plain register port driven on CLK_I, and that interrupt
// requests and the idle request come from logic on the same clock.
//
// Contract
// - Ratio field sets output clock rate
// - Ratio field resets to all ones
// - Idle stops CPU clocks, peripherals keep running in CPU-only sleep
// - Separate CPU and system clock domains
// - Bits 13:12 select the sleep depth
// - CPU-only sleep; wakes on peripheral or external interrupts or protect, not on the wakeup interrupt
// - Domain-stop sleep stops both domains
// - Domain-stop keeps loop running; defined wake set
// - Halt stops oscillator, loop, watchdog; protect wakes
// - Peripheral clock enables, all off after reset
`timescale 1ns/1ps
module pcl_top
   import pcl_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DATA_W-1:0] RDATA_O,
   input wire logic IDLE_REQ_I,
   input wire logic PERIPH_IRQ_I,
   input wire logic WAKE_IRQ_I,
   input wire logic EXT_IRQ_I,
   input wire logic POWER_DRIVE_PROTECT_IN_I,
   output logic CPU_CLK_EN_O,
   output logic SYS_CLK_EN_O,
   output logic CORE_OUT_CLK_EN_O,
   output logic [PER_N-1:0] PERIPH_CLK_EN_O,
   output logic WATCHDOG_CLK_EN_O,
   output logic PLL_ON_O,
   output logic OSC_ON_O,
   output logic SLEEP_O
);

   // Number of gated enables: CPU, system, watchdog, peripherals
   localparam int GATE_N = PER_N + 3;

   // Whole block state
   typedef struct packed {
      pcl_mode_t st;              // Operating mode
      logic [2:0] ratio;          // Ratio select code
      logic [1:0] lowpow;         // Sleep depth selector
      logic [PER_N-1:0] per_en;   // Peripheral clock enables
      logic [1:0] pdp_sync;       // Protect pin synchroniser
      logic [1:0] ext_sync;       // External interrupt synchroniser
      logic [DATA_W-1:0] rdata;   // Read data
   } pcl_state_t;

   pcl_state_t s_q; // Registered state
   pcl_state_t s_d; // Next state

   logic ref_tick;               // Reference rate pulse
   logic core_tick;              // Output clock rate pulse
   logic [4:0] div_act;          // Divisor in effect
   logic pdp_s;                  // Synchronised protect input
   logic ext_s;                  // Synchronised external interrupt
   logic cpu_on;                 // CPU domain wanted on
   logic sys_on;                 // System domain wanted on
   logic pll_on;                 // Loop running
   logic osc_on;                 // Oscillator running
   logic [GATE_N-1:0] gate_tick; // Tick source per gate
   logic [GATE_N-1:0] gate_on;   // Request per gate
   logic [GATE_N-1:0] gate_en;   // Gated enable per gate

   // Second synchroniser stages only
   assign pdp_s = s_q.pdp_sync[1];
   assign ext_s = s_q.ext_sync[1];

   // Domain requests from the mode
   always_comb begin
      cpu_on = (s_q.st == PCL_RUN);
      sys_on = (s_q.st == PCL_RUN) ||
               (s_q.st == PCL_CPU_ONLY_SLEEP);
      pll_on = (s_q.st != PCL_DEEP_HALT_SLEEP);
      osc_on = (s_q.st != PCL_DEEP_HALT_SLEEP);
   end

   // Ratio divider and reference tick
   pcl_ratio_gen u_ratio (
      .clk_i(CLK_I),
      .rst_n_i(RESET_N_I),
      .osc_on_i(osc_on),
      .pll_on_i(pll_on),
      .sel_i(s_q.ratio),
      .ref_tick_o(ref_tick),
      .out_tick_o(core_tick),
      .div_act_o(div_act)
   );

   // Gate sources: 0 CPU, 1 system, 2 watchdog, rest peripherals
   always_comb begin
      gate_tick = {GATE_N{core_tick}};
      gate_tick[2] = ref_tick;
      gate_on = {s_q.per_en & {PER_N{sys_on}}, osc_on, sys_on, cpu_on};
   end

   // One glitch-free gate per gated clock enable
   genvar gi;
   generate
      for (gi = 0; gi < GATE_N; gi++) begin : g_gate
         pcl_clk_gate u_gate (
            .clk_i(CLK_I),
            .rst_n_i(RESET_N_I),
            .tick_i(gate_tick[gi]),
            .on_i(gate_on[gi]),
            .en_o(gate_en[gi])
         );
      end
   endgenerate

   // Next state: registers, synchronisers and mode sequencing
   always_comb begin
      s_d = s_q;
      // Pin synchronisers
      s_d.pdp_sync = {s_q.pdp_sync[0], POWER_DRIVE_PROTECT_IN_I};
      s_d.ext_sync = {s_q.ext_sync[0], EXT_IRQ_I};
      // Register write
      if (WR_I && ADDR_I == SYSCTL_ADDR) begin
         s_d.ratio = WDATA_I[RATIO_MSB:RATIO_LSB];
         s_d.lowpow = WDATA_I[LOWPOW_SEL_HI:LOWPOW_SEL_LO];
         s_d.per_en = WDATA_I[PER_LSB+PER_N-1:PER_LSB];
      end
      // Read data stand one cycle, zero otherwise
      s_d.rdata = '0;
      if (RD_I) begin
         case (ADDR_I)
            SYSCTL_ADDR: begin
               s_d.rdata[RATIO_MSB:RATIO_LSB] = s_q.ratio;
               s_d.rdata[LOWPOW_SEL_HI:LOWPOW_SEL_LO] = s_q.lowpow;
               s_d.rdata[PER_LSB+PER_N-1:PER_LSB] = s_q.per_en;
            end
            STATUS_ADDR: begin
               s_d.rdata[STAT_DIV_LSB+4:STAT_DIV_LSB] = div_act;
               s_d.rdata[STAT_PDP_BIT] = pdp_s;
               s_d.rdata[STAT_EXT_BIT] = ext_s;
            end
            // Unmapped reads give zero
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end
      // Mode sequencing
      case (s_q.st)
         PCL_RUN: begin
            // Idle instruction enters the selected depth
            if (IDLE_REQ_I) begin
               if (s_q.lowpow[1]) begin
                  // Flash is left to software
                  s_d.st = PCL_DEEP_HALT_SLEEP;
               end else if (s_q.lowpow == LOWPOW_DOMAIN_STOP) begin
                  s_d.st = PCL_DOMAIN_STOP_SLEEP;
               end else begin
                  s_d.st = PCL_CPU_ONLY_SLEEP;
               end
            end
         end
         PCL_CPU_ONLY_SLEEP: begin
            // Peripheral, external or protect wake
            if (PERIPH_IRQ_I || ext_s || pdp_s) begin
               s_d.st = PCL_RUN;
            end
         end
         PCL_DOMAIN_STOP_SLEEP: begin
            // Wakeup, external or protect wake
            if (WAKE_IRQ_I || ext_s || pdp_s) begin
               s_d.st = PCL_RUN;
            end
         end
         PCL_DEEP_HALT_SLEEP: begin
            // Only the protect input or reset leaves halt
            if (pdp_s) begin
               s_d.st = PCL_RUN;
            end
         end
         default: begin
            s_d.st = PCL_RUN;
         end
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         s_q <= '{st: PCL_RUN, ratio: RATIO_RESET, lowpow: LOWPOW_RESET,
                  per_en: PER_RESET, pdp_sync: 2'h0, ext_sync: 2'h0,
                  rdata: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign RDATA_O = s_q.rdata;
   assign CORE_OUT_CLK_EN_O = core_tick;
   assign CPU_CLK_EN_O = gate_en[0];
   assign SYS_CLK_EN_O = gate_en[1];
   assign WATCHDOG_CLK_EN_O = gate_en[2];
   assign PERIPH_CLK_EN_O = gate_en[GATE_N-1:3];
   assign PLL_ON_O = pll_on;
   assign OSC_ON_O = osc_on;
   assign SLEEP_O = (s_q.st != PCL_RUN);

   // Helper: cycles since the last output tick
   logic [4:0] gap_q;
   logic seen_q;
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I || !pll_on) begin
         gap_q <= 5'h00;
         seen_q <= 1'b0;
      end else if (core_tick) begin
         gap_q <= 5'h00;
         seen_q <= 1'b1;
      end else if (gap_q != 5'h1f) begin
         gap_q <= gap_q + 5'h01;
      end
   end

   // Checks
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   // Three cycles in one mode let every gate settle
   sequence domain_stop_held_s;
      (s_q.st == PCL_DOMAIN_STOP_SLEEP)[*3];
   endsequence
   sequence halt_held_s;
      (s_q.st == PCL_DEEP_HALT_SLEEP)[*3];
   endsequence
   sequence run_sleep_req_s;
      (s_q.st == PCL_RUN) && IDLE_REQ_I;
   endsequence

   ratio_period_a: assert property (
      (core_tick && seen_q) |-> (gap_q == div_act - 5'h01))
      else $error("output tick spacing differs from ratio");

   ratio_reset_a: assert property (
      $rose(RESET_N_I) |-> (s_q.ratio == 3'h7 && div_act == 5'h10))
      else $error("ratio not all ones after reset");

   cpu_stop_a: assert property (
      (s_q.st != PCL_RUN)[*3] |-> !CPU_CLK_EN_O)
      else $error("CPU clock runs while asleep");

   sys_running_a: assert property (
      (s_q.st == PCL_CPU_ONLY_SLEEP) |-> (gap_q < 5'h10 && pll_on))
      else $error("system clock stalled in CPU-only sleep");

   sleep_entry_a: assert property (
      run_sleep_req_s ##0 (s_q.lowpow == 2'h0) |=>
      (s_q.st == PCL_CPU_ONLY_SLEEP))
      else $error("wrong sleep depth for selector 00");

   halt_entry_a: assert property (
      run_sleep_req_s ##0 s_q.lowpow[1] |=>
      (s_q.st == PCL_DEEP_HALT_SLEEP))
      else $error("selector 1x did not enter halt");

   // Wake returns to run, then the CPU gate reopens within one
   // longest output period plus the gate's own settling cycles
   cpu_wake_a: assert property (
      (s_q.st == PCL_CPU_ONLY_SLEEP && (PERIPH_IRQ_I || ext_s || pdp_s))
      |=> (s_q.st == PCL_RUN) ##[0:24] CPU_CLK_EN_O)
      else $error("CPU-only sleep did not wake");

   domain_stop_a: assert property (
      domain_stop_held_s |-> (!SYS_CLK_EN_O && !CPU_CLK_EN_O &&
                              PERIPH_CLK_EN_O == 6'h00))
      else $error("domain clock runs in domain-stop sleep");

   // A source of the wake set leaves domain-stop sleep next cycle
   domain_wake_a: assert property (
      (s_q.st == PCL_DOMAIN_STOP_SLEEP && (WAKE_IRQ_I || ext_s || pdp_s))
      |=> (s_q.st == PCL_RUN))
      else $error("domain-stop sleep did not wake");

   // Without a wake source the mode holds and the loop keeps running
   domain_hold_a: assert property (
      (s_q.st == PCL_DOMAIN_STOP_SLEEP && !WAKE_IRQ_I && !ext_s && !pdp_s)
      |=> (s_q.st == PCL_DOMAIN_STOP_SLEEP && pll_on))
      else $error("domain-stop sleep left or loop stopped");

   halt_stop_a: assert property (
      halt_held_s |-> (!PLL_ON_O && !OSC_ON_O && !WATCHDOG_CLK_EN_O &&
                       !CORE_OUT_CLK_EN_O))
      else $error("clock source runs in halt");

   halt_hold_a: assert property (
      (s_q.st == PCL_DEEP_HALT_SLEEP && !pdp_s) |=>
      (s_q.st == PCL_DEEP_HALT_SLEEP))
      else $error("halt left without protect input");

   per_reset_a: assert property (
      $rose(RESET_N_I) |-> (s_q.per_en == 6'h00) ##1
      (PERIPH_CLK_EN_O == 6'h00))
      else $error("peripheral clocks enabled after reset");

   whole_pulse_a: assert property (
      (SYS_CLK_EN_O || CPU_CLK_EN_O || PERIPH_CLK_EN_O != 6'h00)
      |-> CORE_OUT_CLK_EN_O)
      else $error("gated pulse not aligned to output tick");

endmodule

// ---- src/pcl_pkg.sv ----
// Package for the clock ratio and low power controller.
// Assumes one 20 MHz system clock; every slower rate is an enable pulse.
package pcl_pkg;

   // System clock rate
   localparam int CLK_HZ = 20_000_000;
   // Reference rate is the system clock divided by this count
   localparam int REF_DIV = 8;

   // Register bus widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register word addresses
   localparam logic [ADDR_W-1:0] SYSCTL_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h1;

   // Field positions in the system control word
   localparam int RATIO_LSB = 9;
   localparam int RATIO_MSB = 11;
   localparam int LOWPOW_SEL_LO = 12;
   localparam int LOWPOW_SEL_HI = 13;
   localparam int PER_LSB = 2;
   localparam int PER_N = 6;

   // Field positions in the status word
   localparam int STAT_DIV_LSB = 0;
   localparam int STAT_PDP_BIT = 8;
   localparam int STAT_EXT_BIT = 9;

   // Values after reset
   localparam logic [2:0] RATIO_RESET = 3'h7;
   localparam logic [1:0] LOWPOW_RESET = 2'h0;
   localparam logic [5:0] PER_RESET = 6'h00;
   localparam logic [4:0] DIV_RESET = 5'h10;

   // Low power selector codes
   localparam logic [1:0] LOWPOW_CPU_ONLY = 2'h0;
   localparam logic [1:0] LOWPOW_DOMAIN_STOP = 2'h1;

   // Operating modes
   typedef enum logic [1:0] {
      PCL_RUN,
      PCL_CPU_ONLY_SLEEP,
      PCL_DOMAIN_STOP_SLEEP,
      PCL_DEEP_HALT_SLEEP
   } pcl_mode_t;

   // Ratio code to system clock cycles per output period
   function automatic logic [4:0] pcl_ratio_div(input logic [2:0] code);
      return {1'b0, code, 1'b0} + 5'h02;
   endfunction

endpackage

// ---- src/pcl_clk_gate.sv ----
// Enable gate for one clock domain, built from a tick pulse.
// Assumes tick_i is never high two cycles running.
`timescale 1ns/1ps
module pcl_clk_gate
   import pcl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic on_i,
   output logic en_o
);

   // Gate state
   typedef struct packed {
      logic gate;
   } pcl_gate_t;

   pcl_gate_t s_q; // Registered state
   pcl_gate_t s_d; // Next state

   // Gate may only move between ticks, so no pulse is cut
   always_comb begin
      s_d = s_q;
      if (!tick_i) begin
         s_d.gate = on_i;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Whole pulses only
   assign en_o = tick_i & s_q.gate;

endmodule

// ---- src/pcl_ratio_gen.sv ----
// Ratio divider: reference tick and output clock tick from the system clock.
// Assumes the ratio code may change at any time.
`timescale 1ns/1ps
module pcl_ratio_gen
   import pcl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic osc_on_i,
   input wire logic pll_on_i,
   input wire logic [2:0] sel_i,
   output logic ref_tick_o,
   output logic out_tick_o,
   output logic [4:0] div_act_o
);

   // Divider state
   typedef struct packed {
      logic [4:0] cnt;
      logic [4:0] div;
      logic [2:0] ref_cnt;
   } pcl_div_t;

   pcl_div_t s_q; // Registered state
   pcl_div_t s_d; // Next state

   // Period ends on the last count of the active divisor
   assign out_tick_o = pll_on_i && (s_q.cnt == s_q.div - 5'h01);
   assign ref_tick_o = osc_on_i && (s_q.ref_cnt == 3'(REF_DIV - 1));
   assign div_act_o = s_q.div;

   // Counters; new ratio taken at a period boundary or while the loop is stopped
   always_comb begin
      s_d = s_q;
      if (!osc_on_i) begin
         s_d.ref_cnt = 3'h0;
      end else begin
         s_d.ref_cnt = s_q.ref_cnt + 3'h1;
      end
      if (!pll_on_i) begin
         // Stopped loop restarts with a fresh whole period
         s_d.cnt = 5'h00;
         s_d.div = pcl_ratio_div(sel_i);
      end else if (out_tick_o) begin
         s_d.cnt = 5'h00;
         s_d.div = pcl_ratio_div(sel_i);
      end else begin
         s_d.cnt = s_q.cnt + 5'h01;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '{cnt: 5'h00, div: DIV_RESET, ref_cnt: 3'h0};
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ---- tb/pcl_clk_sink.sv ----
// Consumer model: CPU core and peripherals counting their clock enables.
// Assumes every enable is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module pcl_clk_sink (
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic cpu_en_i,
   input wire logic sys_en_i,
   input wire logic core_en_i,
   input wire logic wd_en_i,
   input wire logic [5:0] per_en_i,
   output logic [7:0] cpu_n_o,
   output logic [7:0] sys_n_o,
   output logic [7:0] core_n_o,
   output logic [7:0] wd_n_o,
   output logic [5:0] per_seen_o,
   output logic dbl_o
);
   // Enables of the previous cycle
   logic [9:0] prev_q;
   // Pulse counters, cleared on request
   always_ff @(posedge clk_i) begin
      prev_q <= {per_en_i, wd_en_i, core_en_i, sys_en_i, cpu_en_i};
      if (clr_i) begin
         cpu_n_o <= 8'h00;
         sys_n_o <= 8'h00;
         core_n_o <= 8'h00;
         wd_n_o <= 8'h00;
         per_seen_o <= 6'h00;
         dbl_o <= 1'b0;
      end else begin
         cpu_n_o <= cpu_n_o + 8'(cpu_en_i);
         sys_n_o <= sys_n_o + 8'(sys_en_i);
         core_n_o <= core_n_o + 8'(core_en_i);
         wd_n_o <= wd_n_o + 8'(wd_en_i);
         per_seen_o <= per_seen_o | per_en_i;
         // Stretched pulse means a cut or merged clock
         if (|(prev_q & {per_en_i, wd_en_i, core_en_i, sys_en_i,
                         cpu_en_i})) begin
            dbl_o <= 1'b1;
         end
      end
   end
endmodule

// ---- tb/pcl_top_tb_top.sv ----
// Self-checking bench for the clock ratio and low power controller.
// Assumes the register map and sleep codes held in pcl_pkg.
`timescale 1ns/1ps
module pcl_top_tb_top
   import pcl_pkg::*;
;
   logic clk, rst_n, wr, rd, idle, clr;
   logic [3:0] addr, src;
   logic [15:0] wdata;
   wire logic [15:0] rdata;
   wire logic cpu_en, sys_en, core_en, wd_en, pll_on, osc_on, sleep;
   wire logic [5:0] per_en, per_seen;
   wire logic [7:0] cpu_n, sys_n, core_n, wd_n;
   wire logic dbl;
   int num_errors = 0;
   int tests_run = 0;
   // Sleep table: selector, system domain alive, oscillator alive
   logic [1:0] sel_t [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
   logic sys_t [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   logic osc_t [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   // Wake sources {protect, external, wakeup, peripheral}
   logic [3:0] bad_t [5] = '{4'h2, 4'h2, 4'h1, 4'h7, 4'h7};
   logic [3:0] good_t [5] = '{4'h1, 4'h4, 4'h2, 4'h8, 4'h8};

   pcl_top uut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .IDLE_REQ_I(idle), .PERIPH_IRQ_I(src[0]), .WAKE_IRQ_I(src[1]),
      .EXT_IRQ_I(src[2]), .POWER_DRIVE_PROTECT_IN_I(src[3]),
      .CPU_CLK_EN_O(cpu_en), .SYS_CLK_EN_O(sys_en),
      .CORE_OUT_CLK_EN_O(core_en), .PERIPH_CLK_EN_O(per_en),
      .WATCHDOG_CLK_EN_O(wd_en), .PLL_ON_O(pll_on), .OSC_ON_O(osc_on),
      .SLEEP_O(sleep));

   pcl_clk_sink sink (.clk_i(clk), .clr_i(clr), .cpu_en_i(cpu_en),
      .sys_en_i(sys_en), .core_en_i(core_en), .wd_en_i(wd_en),
      .per_en_i(per_en), .cpu_n_o(cpu_n), .sys_n_o(sys_n),
      .core_n_o(core_n), .wd_n_o(wd_n), .per_seen_o(per_seen),
      .dbl_o(dbl));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One-cycle register write
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read; data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask

   // Cycles from one output tick to the next, bounded
   task automatic period(input int exp);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (core_en !== 1'b1 && n < 40);
      // No tick at all counts as a failure and ends the run
      if (core_en !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (core_en !== 1'b1 && n < 40);
      check(16'(n), 16'(exp));
   endtask

   // Clear the sink, then let a window of cycles pass
   task automatic window(input int cycles);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (cycles) @(posedge clk);
      #1;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      idle = 1'b0;
      clr = 1'b1;
      src = 4'h0;
      addr = 4'h0;
      wdata = 16'h0000;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      clr <= 1'b0;
      // Reset values
      rd_reg(SYSCTL_ADDR, 16'h0e00);
      rd_reg(STATUS_ADDR, 16'h0010);
      window(40);
      check(16'(per_seen), 16'h0000);
      check(16'(core_n), 16'h0002);
      // Unmapped place: write ignored, read zero
      wr_reg(4'h5, 16'hffff);
      rd_reg(4'h5, 16'h0000);
      rd_reg(SYSCTL_ADDR, 16'h0e00);
      // Every ratio code, output period and status divisor
      for (int c = 0; c < 8; c++) begin
         wr_reg(SYSCTL_ADDR, 16'(c) << RATIO_LSB);
         period(2 * (c + 1));
         period(2 * (c + 1));
         rd_reg(STATUS_ADDR, 16'(2 * (c + 1)));
      end
      // Peripheral enables on, domains both running
      wr_reg(SYSCTL_ADDR, 16'h06fc);
      window(40);
      check(16'(per_seen), 16'h003f);
      check(16'(cpu_n != 0 && sys_n != 0), 16'h0001);
      // Each sleep depth, a refused wake, then the right wake
      for (int i = 0; i < 5; i++) begin
         // Flash assumed powered down by software before halt
         wr_reg(SYSCTL_ADDR, 16'h06fc | (16'(sel_t[i]) << 12));
         @(posedge clk);
         idle <= 1'b1;
         @(posedge clk);
         idle <= 1'b0;
         #1 check(16'(sleep), 16'h0001);
         repeat (3) @(posedge clk);
         window(40);
         check(16'(cpu_n), 16'h0000);
         check(16'(sys_n != 0), 16'(sys_t[i]));
         check(16'(per_seen != 0), 16'(sys_t[i]));
         check(16'(core_n != 0), 16'(osc_t[i]));
         check(16'(wd_n != 0), 16'(osc_t[i]));
         check(16'({pll_on, osc_on}), 16'(osc_t[i] ? 2 : 0) |
            16'(osc_t[i]));
         src <= bad_t[i];
         repeat (6) @(posedge clk);
         #1 check(16'(sleep), 16'h0001);
         // Status: ratio 3 divides by 8, pin levels through synchroniser
         rd_reg(STATUS_ADDR, 16'h0008 | (16'(bad_t[i][3]) << 8) |
            (16'(bad_t[i][2]) << 9));
         src <= good_t[i];
         repeat (5) @(posedge clk);
         #1 check(16'(sleep), 16'h0000);
         rd_reg(STATUS_ADDR, 16'h0008 | (16'(good_t[i][3]) << 8) |
            (16'(good_t[i][2]) << 9));
         src <= 4'h0;
         window(40);
         check(16'(cpu_n != 0), 16'h0001);
      end
      check(16'(dbl), 16'h0000);
      end_of_test();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
